// >>> rtl/brs_pkg.sv
// brs_pkg: constants shared by the brake and ride-through sequencer
// assumes: 25 MHz system clock, parameters held as scaled integers
package brs_pkg;

  // ****************************************
  // clock and time base
  // ****************************************
  localparam int          CLK_HZ         = 25000000;
  localparam int          TICK_US        = 10000;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000000 * TICK_US;
  localparam logic [17:0] TICK_LAST      = 18'(TICK_CYCLES - 1);

  // ****************************************
  // Wishbone register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL         = 8'h00;
  localparam logic [7:0] OFS_RT_TRIGGER   = 8'h04;
  localparam logic [7:0] OFS_RT_PAUSE     = 8'h08;
  localparam logic [7:0] OFS_RECOVERY     = 8'h0C;
  localparam logic [7:0] OFS_REL_FREQ     = 8'h10;
  localparam logic [7:0] OFS_REL_CURRENT  = 8'h14;
  localparam logic [7:0] OFS_REL_DELAY    = 8'h18;
  localparam logic [7:0] OFS_ACCEL_PAUSE  = 8'h1C;
  localparam logic [7:0] OFS_ENG_FREQ     = 8'h20;
  localparam logic [7:0] OFS_ENG_WAIT     = 8'h24;
  localparam logic [7:0] OFS_STOP_DELAY   = 8'h28;
  localparam logic [7:0] OFS_STATUS       = 8'h2C;

  // ctrl fields
  localparam int CTRL_RT_EN   = 0;
  localparam int CTRL_BRK_EN  = 1;
  localparam int CTRL_SUP_LSB = 4;

  // status fields
  localparam int ST_BRAKE  = 0;
  localparam int ST_RT     = 1;
  localparam int ST_HOLD   = 2;
  localparam int ST_RUN    = 3;
  localparam int ST_PH_LSB = 4;

  // ****************************************
  // reset values (percent x10, Hz x100, time in 10 ms ticks)
  // ****************************************
  localparam logic [15:0] RST_RT_TRIGGER  = 16'h0320;
  localparam logic [15:0] RST_RT_PAUSE    = 16'h03E8;
  localparam logic [15:0] RST_RECOVERY    = 16'h0000;
  localparam logic [15:0] RST_REL_FREQ    = 16'h00FA;
  localparam logic [15:0] RST_REL_CURRENT = 16'h0000;
  localparam logic [15:0] RST_REL_DELAY   = 16'h0000;
  localparam logic [15:0] RST_ACCEL_PAUSE = 16'h0064;
  localparam logic [15:0] RST_ENG_FREQ    = 16'h0000;
  localparam logic [15:0] RST_ENG_WAIT    = 16'h0000;
  localparam logic [15:0] RST_STOP_DELAY  = 16'h0000;

  // ****************************************
  // base bus voltage per supply class, volts
  // ****************************************
  localparam logic [2:0]  SUP_220   = 3'h0;
  localparam logic [2:0]  SUP_400   = 3'h1;
  localparam logic [2:0]  SUP_470   = 3'h2;
  localparam logic [2:0]  SUP_650   = 3'h3;
  localparam logic [2:0]  SUP_1140  = 3'h4;
  localparam logic [11:0] BASE_220  = 12'h137;
  localparam logic [11:0] BASE_400  = 12'h219;
  localparam logic [11:0] BASE_470  = 12'h29E;
  localparam logic [11:0] BASE_650  = 12'h3CF;
  localparam logic [11:0] BASE_1140 = 12'h640;

  // ****************************************
  // brake sequence phases
  // ****************************************
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_WAIT_RELEASE,
    PH_ACCEL_PAUSE,
    PH_RUN,
    PH_DECEL,
    PH_ENG_WAIT,
    PH_STOP_DELAY
  } brs_phase_t;

endpackage

// >>> rtl/brs_sync.sv
// brs_sync: two flip-flop synchroniser for one pin level
// assumes: input is asynchronous to CLK_SYS
`timescale 1ns/100ps
module brs_sync
  import brs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level
  input  wire logic din,
  output logic      dout
);

  logic stage1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

// >>> rtl/brs_timer.sv
// brs_timer: counts 10 ms ticks while enabled, flags once the count reaches limit
// assumes: tick is a one-cycle pulse from the same clock
`timescale 1ns/100ps
module brs_timer
  import brs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  output logic             done
);

  logic [15:0] count;
  logic [15:0] next_count;

  // saturating count, cleared whenever the condition drops
  assign next_count = !run ? 16'h0000 :
                      (tick && count != 16'hFFFF) ? count + 16'h0001 : count;
  assign done       = run && (count >= limit);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= 16'h0000;
    else
      count <= next_count;
  end

endmodule

// >>> rtl/brs_sequencer.sv
// brs_sequencer: power loss ride through and external brake sequencer
// assumes: classic Wishbone slave, frequency/current/voltage from same-clock
// measurement logic, start/stop command pins asynchronous
//
// Functional notes
// - ride-through lowers frequency to hold bus
// - decelerate below trigger percent of base
// - base voltage chosen from supply class
// - recover after normal longer than recovery time
// - pause threshold register, default 100.0 percent
// - start output on start, brake engaged
// - release after current and frequency held delay
// - compare output frequency with release frequency
// - release current is percent of rated
// - hold release frequency for pause time
// - on stop decelerate to engage frequency
// - wait engage time then engage brake
// - after engage wait stop delay, stop
`timescale 1ns/100ps
module brs_sequencer
  import brs_pkg::*;
#(parameter logic [17:0] TICK_TOP = TICK_LAST)  // tick length, shortened only for fast tests
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // commands (pins)
  input  wire logic        START_CMD,
  input  wire logic        STOP_CMD,
  // measurements (same clock)
  input  wire logic [15:0] OUT_FREQ,
  input  wire logic [15:0] SET_FREQ,
  input  wire logic [15:0] OUT_CURRENT,
  input  wire logic [15:0] RATED_CURRENT,
  input  wire logic [11:0] BUS_VOLTAGE,
  // frequency generator control
  output logic             RUN_ENABLE,
  output logic             FREQ_HOLD,
  output logic             FREQ_DECEL,
  output logic [15:0]      FREQ_TARGET,
  // brake terminal, high = brake engaged
  output logic             BRAKE_OUT,
  output logic             BRAKE_OE
);

  // ****************************************
  // helpers
  // ****************************************
  // scale a value by a percent x10 setting, result in value units
  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] pct);
    logic [31:0] prod;
    prod   = base * pct;
    pct_of = 16'(prod / 32'd1000);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl;
  logic [15:0] rt_trigger;
  logic [15:0] rt_pause;
  logic [15:0] recovery;
  logic [15:0] rel_freq;
  logic [15:0] rel_current;
  logic [15:0] rel_delay;
  logic [15:0] accel_pause;
  logic [15:0] eng_freq;
  logic [15:0] eng_wait;
  logic [15:0] stop_delay;
  wire ride_through_enable = ctrl[CTRL_RT_EN];
  wire ext_brake_enable    = ctrl[CTRL_BRK_EN];
  wire [2:0] supply_class  = ctrl[CTRL_SUP_LSB +: 3];

  wire wb_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wb_wr   = wb_req && WB_WE_I;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl        <= 16'h0000;
      rt_trigger  <= RST_RT_TRIGGER;
      rt_pause    <= RST_RT_PAUSE;
      recovery    <= RST_RECOVERY;
      rel_freq    <= RST_REL_FREQ;
      rel_current <= RST_REL_CURRENT;
      rel_delay   <= RST_REL_DELAY;
      accel_pause <= RST_ACCEL_PAUSE;
      eng_freq    <= RST_ENG_FREQ;
      eng_wait    <= RST_ENG_WAIT;
      stop_delay  <= RST_STOP_DELAY;
    end
    else if (wb_wr)
    begin
      case (WB_ADR_I)
        OFS_CTRL:        ctrl        <= merge(ctrl, WB_DAT_I, WB_SEL_I);
        OFS_RT_TRIGGER:  rt_trigger  <= merge(rt_trigger, WB_DAT_I, WB_SEL_I);
        OFS_RT_PAUSE:    rt_pause    <= merge(rt_pause, WB_DAT_I, WB_SEL_I);
        OFS_RECOVERY:    recovery    <= merge(recovery, WB_DAT_I, WB_SEL_I);
        OFS_REL_FREQ:    rel_freq    <= merge(rel_freq, WB_DAT_I, WB_SEL_I);
        OFS_REL_CURRENT: rel_current <= merge(rel_current, WB_DAT_I, WB_SEL_I);
        OFS_REL_DELAY:   rel_delay   <= merge(rel_delay, WB_DAT_I, WB_SEL_I);
        OFS_ACCEL_PAUSE: accel_pause <= merge(accel_pause, WB_DAT_I, WB_SEL_I);
        OFS_ENG_FREQ:    eng_freq    <= merge(eng_freq, WB_DAT_I, WB_SEL_I);
        OFS_ENG_WAIT:    eng_wait    <= merge(eng_wait, WB_DAT_I, WB_SEL_I);
        OFS_STOP_DELAY:  stop_delay  <= merge(stop_delay, WB_DAT_I, WB_SEL_I);
        default:         ctrl        <= ctrl;
      endcase
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic start_s;
  logic stop_s;
  brs_sync u_sync_start (.clk(CLK_SYS), .rst(RST), .din(START_CMD), .dout(start_s));
  brs_sync u_sync_stop  (.clk(CLK_SYS), .rst(RST), .din(STOP_CMD),  .dout(stop_s));

  // ****************************************
  // 10 ms tick
  // ****************************************
  logic [17:0] tick_cnt;
  wire         tick = (tick_cnt == TICK_TOP);
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      tick_cnt <= 18'h00000;
    else
      tick_cnt <= tick ? 18'h00000 : tick_cnt + 18'h00001;
  end
  // ****************************************
  // ride through
  // ****************************************
  logic [11:0] base_v;
  always_comb
  begin
    case (supply_class)
      SUP_220:  base_v = BASE_220;
      SUP_400:  base_v = BASE_400;
      SUP_470:  base_v = BASE_470;
      SUP_650:  base_v = BASE_650;
      SUP_1140: base_v = BASE_1140;
      default:  base_v = BASE_400;
    endcase
  end

  wire [15:0] trig_v   = pct_of({4'h0, base_v}, rt_trigger);
  wire [15:0] pause_v  = pct_of({4'h0, base_v}, rt_pause);
  wire [15:0] bus_v    = {4'h0, BUS_VOLTAGE};
  wire        bus_low  = bus_v < trig_v;
  wire        bus_high = bus_v > pause_v;

  logic rt_active;
  logic recovered;
  // recovery timer runs while bus is back at or above trigger
  brs_timer u_recover (
    .clk   (CLK_SYS),
    .rst   (RST),
    .run   (rt_active && !bus_low),
    .tick  (tick),
    .limit (recovery + 16'h0001),
    .done  (recovered)
  );

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rt_active <= 1'b0;
    else if (!ride_through_enable || !RUN_ENABLE)
      rt_active <= 1'b0;
    else if (bus_low && RUN_ENABLE)
      rt_active <= 1'b1;
    else if (recovered)
      rt_active <= 1'b0;
  end

  // ****************************************
  // brake sequence
  // ****************************************
  brs_phase_t phase;
  brs_phase_t next_phase;
  wire [15:0] rel_i    = pct_of(RATED_CURRENT, rel_current);
  wire        freq_ok  = OUT_FREQ >= rel_freq;
  wire        rel_cond = (OUT_CURRENT > rel_i) && freq_ok;
  wire        at_eng   = OUT_FREQ <= eng_freq;
  logic       tmr_done;
  logic       phase_moved;  // clears the count so no time carries into the next phase
  logic [15:0] tmr_limit;
  wire        tmr_run = (phase == PH_WAIT_RELEASE) ? rel_cond :
                        (phase == PH_ACCEL_PAUSE || phase == PH_STOP_DELAY) ||
                        (phase == PH_ENG_WAIT && at_eng);

  always_comb
  begin
    case (phase)
      PH_WAIT_RELEASE: tmr_limit = rel_delay + 16'h0001;  // longer than delay
      PH_ACCEL_PAUSE:  tmr_limit = accel_pause;
      PH_ENG_WAIT:     tmr_limit = eng_wait;
      PH_STOP_DELAY:   tmr_limit = stop_delay;
      default:         tmr_limit = 16'h0000;
    endcase
  end

  brs_timer u_phase (
    .clk   (CLK_SYS),
    .rst   (RST),
    .run   (tmr_run && !phase_moved),
    .tick  (tick),
    .limit (tmr_limit),
    .done  (tmr_done)
  );

  always_comb
  begin
    next_phase = phase;
    case (phase)
      PH_IDLE:
        if (start_s && !stop_s)
          next_phase = ext_brake_enable ? PH_WAIT_RELEASE : PH_RUN;
      PH_WAIT_RELEASE:
        if (stop_s)
          next_phase = PH_STOP_DELAY;  // brake never released, no engage wait
        else if (tmr_done)
          next_phase = PH_ACCEL_PAUSE;
      PH_ACCEL_PAUSE:
        if (stop_s)
          next_phase = PH_DECEL;
        else if (tmr_done)
          next_phase = PH_RUN;
      PH_RUN:
        if (stop_s)
          next_phase = ext_brake_enable ? PH_DECEL : PH_IDLE;
      PH_DECEL:
        if (at_eng)
          next_phase = PH_ENG_WAIT;
      PH_ENG_WAIT:
        if (tmr_done)
          next_phase = PH_STOP_DELAY;
      PH_STOP_DELAY:
        if (tmr_done)
          next_phase = PH_IDLE;
      default:
        next_phase = PH_IDLE;
    endcase
    // disabling the brake mid-sequence drops straight to plain running, or to idle while stop is held
    if (!ext_brake_enable && phase != PH_IDLE && phase != PH_RUN)
      next_phase = stop_s ? PH_IDLE : PH_RUN;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      phase <= PH_IDLE;
    else
      phase <= next_phase;
  end

  // ****************************************
  // outputs, all registered
  // ****************************************
  logic        next_brake;
  logic        next_hold;
  logic        next_decel;
  logic [15:0] next_target;

  always_comb
  begin
    next_brake  = !ext_brake_enable || !(phase == PH_ACCEL_PAUSE || phase == PH_RUN ||
                                         phase == PH_DECEL || phase == PH_ENG_WAIT);
    next_target = SET_FREQ;
    next_hold   = 1'b0;
    next_decel  = 1'b0;
    case (phase)
      PH_WAIT_RELEASE: next_target = rel_freq;
      PH_ACCEL_PAUSE:
      begin
        next_target = rel_freq;
        next_hold   = 1'b1;
      end
      PH_DECEL, PH_ENG_WAIT, PH_STOP_DELAY: next_target = eng_freq;
      default: next_target = SET_FREQ;
    endcase
    // ride through overrides the normal ramp
    if (rt_active && phase != PH_IDLE)
    begin
      next_decel = !bus_high;
      next_hold  = bus_high;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      RUN_ENABLE  <= 1'b0;
      FREQ_HOLD   <= 1'b0;
      FREQ_DECEL  <= 1'b0;
      FREQ_TARGET <= 16'h0000;
      BRAKE_OUT   <= 1'b1;
      BRAKE_OE    <= 1'b0;
      phase_moved <= 1'b0;
    end
    else
    begin
      RUN_ENABLE  <= (phase != PH_IDLE);
      FREQ_HOLD   <= next_hold;
      FREQ_DECEL  <= next_decel;
      FREQ_TARGET <= next_target;
      BRAKE_OUT   <= next_brake;
      BRAKE_OE    <= ext_brake_enable;
      phase_moved <= (next_phase != phase);
    end
  end

  // ****************************************
  // wishbone read and ack
  // ****************************************
  logic [15:0] rd_mux;
  always_comb
  begin
    case (WB_ADR_I)
      OFS_CTRL:        rd_mux = ctrl;
      OFS_RT_TRIGGER:  rd_mux = rt_trigger;
      OFS_RT_PAUSE:    rd_mux = rt_pause;
      OFS_RECOVERY:    rd_mux = recovery;
      OFS_REL_FREQ:    rd_mux = rel_freq;
      OFS_REL_CURRENT: rd_mux = rel_current;
      OFS_REL_DELAY:   rd_mux = rel_delay;
      OFS_ACCEL_PAUSE: rd_mux = accel_pause;
      OFS_ENG_FREQ:    rd_mux = eng_freq;
      OFS_ENG_WAIT:    rd_mux = eng_wait;
      OFS_STOP_DELAY:  rd_mux = stop_delay;
      OFS_STATUS:      rd_mux = {9'h000, phase, RUN_ENABLE, FREQ_HOLD, rt_active, BRAKE_OUT};
      default:         rd_mux = 16'h0000;
    endcase
  end
  // unmapped addresses still ack, reading zero, so the bus never hangs
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

endmodule

// >>> testbench/brs_seq_chk.sv
// brs_seq_chk: port-level assertions on the brake and ride-through sequencer
// assumes: bound to brs_sequencer, single clock CLK_SYS, async RST
`timescale 1ns/100ps
module brs_seq_chk
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // sequencer outputs
  input wire logic        RUN_ENABLE,
  input wire logic        FREQ_HOLD,
  input wire logic        FREQ_DECEL,
  input wire logic        BRAKE_OUT,
  input wire logic        BRAKE_OE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // ****************************************
  // assertions
  // ****************************************
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  a_undriven_engaged: assert property (!BRAKE_OE |-> BRAKE_OUT)
    else $error("brake released while undriven");
  a_stop_engaged: assert property (!RUN_ENABLE |-> BRAKE_OUT)
    else $error("brake released while not running");
  a_release_hold: assert property ($fell(BRAKE_OUT) |-> FREQ_HOLD && RUN_ENABLE)
    else $error("release without frequency hold");
  a_engage_running: assert property ($rose(BRAKE_OUT) && BRAKE_OE |-> RUN_ENABLE)
    else $error("brake engaged only after stop");
  a_decel_running: assert property (FREQ_DECEL |-> RUN_ENABLE)
    else $error("decelerate while stopped");
  a_hold_running: assert property (FREQ_HOLD |-> RUN_ENABLE)
    else $error("hold while stopped");

  c_release: cover property ($fell(BRAKE_OUT));
  c_decel: cover property ($rose(FREQ_DECEL));
  c_hold: cover property ($rose(FREQ_HOLD) && !BRAKE_OE);
endmodule

bind brs_sequencer brs_seq_chk u_brs_seq_chk (
  .CLK_SYS    (CLK_SYS),
  .RST        (RST),
  .WB_CYC_I   (WB_CYC_I),
  .WB_STB_I   (WB_STB_I),
  .WB_ACK_O   (WB_ACK_O),
  .WB_DAT_O   (WB_DAT_O),
  .RUN_ENABLE (RUN_ENABLE),
  .FREQ_HOLD  (FREQ_HOLD),
  .FREQ_DECEL (FREQ_DECEL),
  .BRAKE_OUT  (BRAKE_OUT),
  .BRAKE_OE   (BRAKE_OE)
);

// >>> testbench/brs_drive_model.sv
// brs_drive_model: frequency generator and load seen by the sequencer
// assumes: same clock as the sequencer, one count of ramp per cycle
`timescale 1ns/100ps
module brs_drive_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control from sequencer
  input  wire logic        run_enable,
  input  wire logic        freq_hold,
  input  wire logic        freq_decel,
  input  wire logic [15:0] freq_target,
  input  wire logic [15:0] load,
  // measurements
  output logic      [15:0] out_freq,
  output logic      [15:0] out_current
);
  // current only flows while the output runs
  assign out_current = run_enable ? load : 16'h0000;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      out_freq <= 16'h0000;
    else if (!run_enable)
      out_freq <= 16'h0000;
    else if (freq_decel && out_freq != 16'h0000)
      out_freq <= out_freq - 16'h0001;
    else if (freq_hold || freq_decel)
      out_freq <= out_freq;
    else if (out_freq < freq_target)
      out_freq <= out_freq + 16'h0001;
    else if (out_freq > freq_target)
      out_freq <= out_freq - 16'h0001;
endmodule

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for brs_sequencer
// assumes: bench plays bus master, command pins and bus voltage monitor
`timescale 1ns/100ps
module tb_top;
  import brs_pkg::*;
  logic        CLK_SYS = 1'b0, RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [3:0]  WB_SEL_I = 4'h3;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
  logic        WB_ACK_O, START_CMD = 1'b0, STOP_CMD = 1'b0;
  logic [15:0] OUT_FREQ, OUT_CURRENT, FREQ_TARGET, load = 16'h0000;
  logic [11:0] BUS_VOLTAGE = 12'h1F4;
  logic        RUN_ENABLE, FREQ_HOLD, FREQ_DECEL, BRAKE_OUT, BRAKE_OE;
  int          fail_count = 0, compares = 0;
  typedef struct { logic [2:0] sup; logic [11:0] base; } brs_row_t;
  brs_row_t    rows [5] = '{'{SUP_220, 12'h137}, '{SUP_400, 12'h219},
                           '{SUP_470, 12'h29E}, '{SUP_650, 12'h3CF}, '{SUP_1140, 12'h640}};

  initial forever #20 CLK_SYS = ~CLK_SYS;

  // short tick of a thousand cycles keeps each timed phase to a few ticks of that length
  brs_sequencer #(.TICK_TOP(18'h003E7)) u_brs_sequencer (.CLK_SYS(CLK_SYS), .RST(RST),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .START_CMD(START_CMD),
    .STOP_CMD(STOP_CMD), .OUT_FREQ(OUT_FREQ), .SET_FREQ(16'h03E8), .OUT_CURRENT(OUT_CURRENT),
    .RATED_CURRENT(16'h03E8), .BUS_VOLTAGE(BUS_VOLTAGE), .RUN_ENABLE(RUN_ENABLE),
    .FREQ_HOLD(FREQ_HOLD), .FREQ_DECEL(FREQ_DECEL), .FREQ_TARGET(FREQ_TARGET),
    .BRAKE_OUT(BRAKE_OUT), .BRAKE_OE(BRAKE_OE));

  brs_drive_model u_brs_drive_model (.clk(CLK_SYS), .rst(RST), .run_enable(RUN_ENABLE),
    .freq_hold(FREQ_HOLD), .freq_decel(FREQ_DECEL), .freq_target(FREQ_TARGET),
    .load(load), .out_freq(OUT_FREQ), .out_current(OUT_CURRENT));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // ack is sampled at the edge, before that edge's own update lands
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    WB_CYC_I <= 1'b1; WB_STB_I <= 1'b1; WB_WE_I <= we;
    WB_ADR_I <= adr; WB_DAT_I <= dat; WB_SEL_I <= sel;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (WB_ACK_O !== 1'b1 && n < 50);
    rd = WB_DAT_O;
    if (n >= 50) check(1'b0, 1'b1, "bus ack missing");
    WB_CYC_I <= 1'b0; WB_STB_I <= 1'b0; WB_WE_I <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  // waits until the selected output reaches v, or flags a hang
  task automatic wait_on(input int which, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge CLK_SYS);
      case (which)
        0:       s = BRAKE_OUT;
        1:       s = RUN_ENABLE;
        2:       s = FREQ_HOLD;
        default: s = FREQ_DECEL;
      endcase
      if (s === v) return;
    end
    check(which, 32'hFF, "output never changed");
  endtask

  task automatic do_reset();
    RST <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
  endtask

  task automatic pulse_start();
    START_CMD <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    START_CMD <= 1'b0;
    wait_on(1, 1'b1, 20);
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    fail_count++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge CLK_SYS);
    check(BRAKE_OUT, 1'b1, "brake not engaged in reset");
    check({BRAKE_OE, RUN_ENABLE, WB_ACK_O}, 3'h0, "outputs active in reset");
    do_reset();
    wb(1'b0, OFS_RT_TRIGGER, 32'h0, 4'h3); check(rd, 32'h0320, "trigger default");
    wb(1'b0, OFS_RT_PAUSE, 32'h0, 4'h3); check(rd, 32'h03E8, "pause default");
    wb(1'b0, OFS_REL_FREQ, 32'h0, 4'h3); check(rd, 32'h00FA, "release freq default");
    wb(1'b0, OFS_ACCEL_PAUSE, 32'h0, 4'h3); check(rd, 32'h0064, "pause time default");
    wb(1'b1, OFS_STATUS, 32'hFF, 4'h3);
    wb(1'b0, OFS_STATUS, 32'h0, 4'h3); check(rd, 32'h0001, "status writable");
    wb(1'b0, 8'h30, 32'h0, 4'h3); check(rd, 32'h0, "unmapped reads nonzero");
    wb(1'b1, OFS_RT_PAUSE, 32'h12AB, 4'h1);
    wb(1'b0, OFS_RT_PAUSE, 32'h0, 4'h3); check(rd, 32'h03AB, "byte lane write");

    // supply class rows: threshold at 100 percent equals base voltage
    foreach (rows[i])
    begin
      do_reset();
      BUS_VOLTAGE <= rows[i].base;
      wb(1'b1, OFS_CTRL, {25'h0, rows[i].sup, 4'h1}, 4'h3);
      wb(1'b1, OFS_RT_TRIGGER, 32'h03E8, 4'h3);
      pulse_start();
      check(BRAKE_OE, 1'b0, "brake driven while disabled");
      check(FREQ_TARGET, 32'h03E8, "target not set freq");
      repeat (20) @(posedge CLK_SYS);
      check(FREQ_DECEL, 1'b0, "decel at base voltage");
      BUS_VOLTAGE <= rows[i].base - 12'h001;
      repeat (20) @(posedge CLK_SYS);
      check(FREQ_DECEL, 1'b1, "no decel below base");
    end

    // pause level below trigger: hold, then decel, then recovery
    do_reset();
    BUS_VOLTAGE <= 12'h1F4;
    wb(1'b1, OFS_CTRL, 32'h11, 4'h3);
    wb(1'b1, OFS_RT_PAUSE, 32'h02BC, 4'h3);
    wb(1'b1, OFS_RECOVERY, 32'h0002, 4'h3);
    pulse_start();
    BUS_VOLTAGE <= 12'h190;
    repeat (20) @(posedge CLK_SYS);
    check({FREQ_HOLD, FREQ_DECEL}, 2'b10, "no hold above pause");
    BUS_VOLTAGE <= 12'h15E;
    repeat (20) @(posedge CLK_SYS);
    check({FREQ_HOLD, FREQ_DECEL}, 2'b01, "no decel below pause");
    BUS_VOLTAGE <= 12'h1F4;
    repeat (20) @(posedge CLK_SYS);
    check({FREQ_HOLD, FREQ_DECEL}, 2'b10, "recovered too early");
    wait_on(2, 1'b0, 5000);
    repeat (2) @(posedge CLK_SYS);
    check({FREQ_HOLD, FREQ_TARGET}, 17'h003E8, "no return to set freq");

    // brake sequence, all delays at zero ticks
    do_reset();
    wb(1'b1, OFS_CTRL, 32'h02, 4'h3);
    wb(1'b1, OFS_ACCEL_PAUSE, 32'h0, 4'h3);
    wb(1'b1, OFS_ENG_FREQ, 32'h0064, 4'h3);
    wb(1'b1, OFS_REL_CURRENT, 32'h0064, 4'h3);
    pulse_start();
    check({BRAKE_OE, BRAKE_OUT}, 2'b11, "brake not engaged at start");
    check(FREQ_TARGET, 32'h00FA, "target not release freq");
    load <= 16'h0064;
    repeat (1100) @(posedge CLK_SYS);
    check(BRAKE_OUT, 1'b1, "released at current threshold");
    load <= 16'h0065;
    wait_on(0, 1'b0, 600000);
    check(FREQ_HOLD, 1'b1, "no hold after release");
    check(OUT_FREQ, 32'h00FA, "release below release freq");
    wait_on(2, 1'b0, 600000);
    repeat (2) @(posedge CLK_SYS);
    check(FREQ_TARGET, 32'h03E8, "no accel to set freq");
    STOP_CMD <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    check(FREQ_TARGET, 32'h0064, "target not engage freq");
    check(BRAKE_OUT, 1'b0, "engaged before engage freq");
    wait_on(0, 1'b1, 600000);
    check(RUN_ENABLE, 1'b1, "stopped before brake engaged");
    check(OUT_FREQ <= 16'h0064, 1'b1, "engaged above engage freq");
    wait_on(1, 1'b0, 600000);
    check(BRAKE_OUT, 1'b1, "brake off after stop");
    STOP_CMD <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    print_verdict();
  end
endmodule
